// ===== logic/host_port_burst.sv
// host port burst access logic, separate read and write strobe mode
// Behaviour
// - first burst read is an ordinary single read fixing the start location.
// - address captured on falling latch strobe as burst start.
// - falling read strobe enables data outputs with addressed contents.
// - ready drops low right after read strobe falls.
// - ready rises once read data is stable.
// - later burst reads advance the latched address before driving data.
// - burst reads return start plus one, plus two, from the counter.
// - rising latch strobe ends burst; no more incrementing.
// - after a burst, single or new burst access needs no recovery.
// - first write: read strobe high, write strobe low enables input.
// - rising write strobe captures data into addressed location.
// - later burst writes advance the address on falling write strobe.
`timescale 1ns/1ps
`default_nettype none
module host_port_burst
  import host_port_pkg::*;
#(
  parameter int SETTLE = host_port_pkg::SETTLE_CYC
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire host_port_pkg::host_pins_t pins,
  output logic [host_port_pkg::DATA_W-1:0] data_out,
  output logic data_oe,
  output logic data_in_en,
  output logic host_ready,
  output logic burst_active
);
  import host_port_pkg::*;

  // store read plus output register: ready must not beat the data
  localparam int SETTLE_MIN = 2;
  localparam int SETTLE_USE = (SETTLE < SETTLE_MIN) ? SETTLE_MIN : SETTLE;

  logic ale_ff;
  logic rd_n_ff;
  logic wr_n_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [ADDR_W-1:0] nxt_addr;
  logic burst_ff;
  logic first_done_ff;
  logic [7:0] settle_ff;
  access_state_t state_ff;
  logic sel;
  logic ale_fall;
  logic ale_rise;
  logic rd_fall;
  logic wr_fall;
  logic wr_rise;
  logic mode_ok;
  logic [DATA_W-1:0] store_rd;

  // wrapping increment of the latched address
  function automatic logic [ADDR_W-1:0] bump(input logic [ADDR_W-1:0] a);
    bump = a + ADDR_STEP;
  endfunction

  // ************************************************
  // edge detection on the strobes
  // ************************************************
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ale_ff <= 1'b0;
      rd_n_ff <= 1'b1;
      wr_n_ff <= 1'b1;
    end
    else
    begin
      ale_ff <= pins.addr_latch_strobe;
      rd_n_ff <= pins.read_strobe_n;
      wr_n_ff <= pins.write_strobe_n;
    end
  end

  // access only when selected in separate strobe mode
  assign mode_ok = !pins.bus_style_select;
  assign sel = !pins.chip_select_n && mode_ok;
  assign ale_fall = ale_ff && !pins.addr_latch_strobe;
  assign ale_rise = !ale_ff && pins.addr_latch_strobe;
  // strobe falls outside idle are refused
  assign rd_fall = sel && rd_n_ff && !pins.read_strobe_n
                   && (state_ff == ST_IDLE);
  assign wr_fall = sel && wr_n_ff && !pins.write_strobe_n
                   && pins.read_strobe_n
                   && (state_ff == ST_IDLE);
  assign wr_rise = !wr_n_ff && pins.write_strobe_n;

  // ************************************************
  // latched address and burst tracking
  // ************************************************
  always_comb
  begin
    nxt_addr = addr_ff;
    if (sel && ale_fall)
    begin
      nxt_addr = pins.addr;
    end
    else if (burst_ff && first_done_ff && (rd_fall || wr_fall))
    begin
      nxt_addr = bump(addr_ff);
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      addr_ff <= ADDR_RESET;
    end
    else
    begin
      addr_ff <= nxt_addr;
    end
  end

  // burst opens at address latch, closes on rising latch strobe
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      burst_ff <= 1'b0;
      first_done_ff <= 1'b0;
    end
    else if (ale_rise)
    begin
      burst_ff <= 1'b0;
      first_done_ff <= 1'b0;
    end
    else if (sel && ale_fall)
    begin
      burst_ff <= 1'b1;
      first_done_ff <= 1'b0;
    end
    else if (burst_ff && (rd_fall || wr_fall))
    begin
      first_done_ff <= 1'b1;
    end
  end

  // ************************************************
  // access sequencing and ready handshake
  // ************************************************
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_ff <= ST_IDLE;
      settle_ff <= 8'h00;
    end
    else
    begin
      unique case (state_ff)
        ST_IDLE:
        begin
          if (rd_fall)
          begin
            state_ff <= ST_WAIT;
            settle_ff <= 8'(SETTLE_USE);
          end
          else if (wr_fall)
          begin
            state_ff <= ST_WRITE;
          end
        end
        ST_WAIT:
        begin
          if (pins.read_strobe_n)
          begin
            state_ff <= ST_IDLE;
          end
          else if (settle_ff <= 8'h01)
          begin
            state_ff <= ST_READY;
          end
          else
          begin
            settle_ff <= settle_ff - 8'h01;
          end
        end
        ST_READY:
        begin
          if (pins.read_strobe_n)
          begin
            state_ff <= ST_IDLE;
          end
        end
        ST_WRITE:
        begin
          if (pins.write_strobe_n)
          begin
            state_ff <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ready low from strobe fall until data settles
  assign host_ready = !(rd_fall || state_ff == ST_WAIT);
  assign data_oe = (state_ff == ST_WAIT) || (state_ff == ST_READY);
  assign data_in_en = (state_ff == ST_WRITE);
  assign burst_active = burst_ff;

  // read data register
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      data_out <= DATA_RESET;
    end
    else
    begin
      data_out <= store_rd;
    end
  end

  host_reg_store #(.DEPTH(1 << ADDR_W)) u_store (
    .clk(clk),
    .reset_n(reset_n),
    .wr_en(state_ff == ST_WRITE && wr_rise),
    .wr_addr(addr_ff),
    .wr_data(pins.data_in),
    .rd_addr(addr_ff),
    .rd_data(store_rd)
  );

  // ************************************************
  // checks
  // ************************************************
  chk_ready_low: assert property (@(posedge clk) disable iff (!reset_n)
    rd_fall |-> !host_ready) else $error("ready not low");
  chk_ready_rise: assert property (@(posedge clk) disable iff (!reset_n)
    (rd_fall && SETTLE_USE == 2) ##1 !pins.read_strobe_n [*2]
    |-> ##1 (host_ready && data_oe)) else $error("ready late");
  chk_oe_read: assert property (@(posedge clk) disable iff (!reset_n)
    rd_fall |=> data_oe) else $error("no drive");
  chk_addr_latch: assert property (@(posedge clk) disable iff (!reset_n)
    (sel && ale_fall) |=> addr_ff == $past(pins.addr))
    else $error("addr not latched");
  chk_addr_step: assert property (@(posedge clk) disable iff (!reset_n)
    (burst_ff && first_done_ff && rd_fall && !ale_rise)
    |=> addr_ff == bump($past(addr_ff))) else $error("no step");
  chk_wr_step: assert property (@(posedge clk) disable iff (!reset_n)
    (burst_ff && first_done_ff && wr_fall && !ale_rise)
    |=> addr_ff == bump($past(addr_ff))) else $error("no wstep");
  chk_burst_end: assert property (@(posedge clk) disable iff (!reset_n)
    ale_rise |=> !burst_ff) else $error("burst open");
  chk_deselect: assert property (@(posedge clk) disable iff (!reset_n)
    (!sel && state_ff == ST_IDLE) |=> !data_oe && !data_in_en)
    else $error("acted unselected");
  chk_write_en: assert property (@(posedge clk) disable iff (!reset_n)
    wr_fall |=> data_in_en) else $error("no input");
  cov_burst_read: cover property (@(posedge clk) disable iff (!reset_n)
    burst_ff && first_done_ff && rd_fall);
  cov_burst_write: cover property (@(posedge clk) disable iff (!reset_n)
    burst_ff && first_done_ff && wr_fall);
  cov_burst_end: cover property (@(posedge clk) disable iff (!reset_n)
    burst_ff && ale_rise);
endmodule // host_port_burst
`default_nettype wire

// ===== logic/host_port_pkg.sv
// package: constants and carrier types for the host port burst logic
package host_port_pkg;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  // read data settling time before ready rises
  localparam int CLK_MHZ = 10;
  localparam int SETTLE_NS = 200;
  localparam int SETTLE_CYC = ((SETTLE_NS * CLK_MHZ) + 999) / 1000;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 7'h00;
  localparam logic [ADDR_W-1:0] ADDR_STEP = 7'h01;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

  // host-side pin group, sampled synchronously
  typedef struct packed {
    logic chip_select_n;
    logic addr_latch_strobe;
    logic read_strobe_n;
    logic write_strobe_n;
    logic bus_style_select;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data_in;
  } host_pins_t;

  // access state
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WAIT = 4'b0010,
    ST_READY = 4'b0100,
    ST_WRITE = 4'b1000
  } access_state_t;
endpackage

// ===== logic/host_reg_store.sv
// storage array behind the host port, one byte per location
`timescale 1ns/1ps
`default_nettype none
module host_reg_store
  import host_port_pkg::*;
#(
  parameter int DEPTH = 128
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wr_en,
  input wire logic [host_port_pkg::ADDR_W-1:0] wr_addr,
  input wire logic [host_port_pkg::DATA_W-1:0] wr_data,
  input wire logic [host_port_pkg::ADDR_W-1:0] rd_addr,
  output logic [host_port_pkg::DATA_W-1:0] rd_data
);
  logic [DATA_W-1:0] mem [DEPTH];

  // ************************************************
  // write port and registered read
  // ************************************************
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  // registered read data
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rd_data <= DATA_RESET;
    end
    else
    begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule // host_reg_store
`default_nettype wire

// ===== tb/host_model.sv
// host side model that drives the burst port pins
`timescale 1ns/1ps
`default_nettype none
module host_model
  import host_port_pkg::*;
(
  input wire logic clk,
  input wire logic host_ready,
  input wire logic data_oe,
  input wire logic data_in_en,
  input wire logic [host_port_pkg::DATA_W-1:0] data_out,
  output var host_port_pkg::host_pins_t pins,
  output logic rd_done,
  output logic [host_port_pkg::DATA_W-1:0] rd_val,
  output logic rd_ok,
  output logic wr_done,
  output logic wr_ok,
  output logic tmo
);
  // ****************
  // host bus cycles
  // ****************
  // idle pins, read and write strobes high, latch strobe low
  initial
  begin
    pins = '1;
    pins.addr_latch_strobe = 1'b0;
    pins.chip_select_n = 1'b0;
    pins.bus_style_select = 1'b0;
    {rd_done, rd_val, rd_ok, wr_done, wr_ok, tmo} = '0;
  end
  // advance n edges then settle
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // select and bus style levels
  task automatic mode(input logic cs_n, input logic style);
    pins.chip_select_n = cs_n;
    pins.bus_style_select = style;
  endtask
  // address phase, latch strobe high then low
  task automatic latch(input logic [ADDR_W-1:0] a);
    step(1);
    pins.addr = a;
    pins.addr_latch_strobe = 1'b1;
    step(1);
    pins.addr_latch_strobe = 1'b0;
    step(1);
  endtask
  // latch strobe rises and stays high
  task automatic end_burst();
    pins.addr_latch_strobe = 1'b1;
    step(2);
  endtask
  // one read, held until ready is sampled high
  task automatic rd();
    int n;
    logic low;
    pins.read_strobe_n = 1'b0;
    #1 low = (host_ready === 1'b0);
    n = 0;
    // ready looked at mid-cycle, where it has settled
    do
    begin
      @(negedge clk);
      n++;
    end
    while (host_ready !== 1'b1 && n < 20);
    rd_val = data_out;
    rd_ok = low && (data_oe === 1'b1);
    tmo = (n >= 20);
    // strobe held through the edge that sees ready high
    @(posedge clk);
    #1 pins.read_strobe_n = 1'b1;
    rd_done = 1'b1;
    step(1);
    rd_done = 1'b0;
    step(1);
  endtask
  // one write, data held past the strobe rise
  task automatic wr(input logic [DATA_W-1:0] d);
    pins.write_strobe_n = 1'b0;
    pins.data_in = d;
    step(2);
    wr_ok = data_in_en;
    pins.write_strobe_n = 1'b1;
    wr_done = 1'b1;
    step(1);
    wr_done = 1'b0;
    step(1);
    pins.data_in = ~d; // stale bus shows inverted value
    step(1);
  endtask
endmodule // host_model
`default_nettype wire

// ===== tb/host_port_burst_bench.sv
// self-checking bench for the host port burst logic
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
 fail_count++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module host_port_burst_bench
  import host_port_pkg::*;
;
  // ****************
  // bench
  // ****************
  logic clk, reset_n, data_oe, data_in_en, host_ready, burst_active;
  logic rd_done, rd_ok, wr_done, wr_ok, tmo, wv;
  logic [DATA_W-1:0] data_out, rd_val, ev;
  logic [DATA_W-1:0] mem [128];
  logic [ADDR_W-1:0] a;
  host_pins_t pins;
  logic [DATA_W-1:0] rq[$];
  logic wq[$];
  int fail_count, n_checks;
  host_port_burst #(.SETTLE(2)) dut (.clk(clk), .reset_n(reset_n),
    .pins(pins), .data_out(data_out), .data_oe(data_oe),
    .data_in_en(data_in_en), .host_ready(host_ready),
    .burst_active(burst_active));
  host_model h (.clk(clk), .host_ready(host_ready), .data_oe(data_oe),
    .data_in_en(data_in_en), .data_out(data_out), .pins(pins),
    .rd_done(rd_done), .rd_val(rd_val), .rd_ok(rd_ok),
    .wr_done(wr_done), .wr_ok(wr_ok), .tmo(tmo));
  // clock
  initial clk = 1'b0;
  always #50 clk = ~clk;
  // verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // watcher takes the oldest note for each result
  always @(posedge clk)
  begin
    if (rd_done === 1'b1)
    begin
      ev = rq.pop_front();
      `CHK("read data", ev, rd_val)
      `CHK("ready seq", 1'b1, rd_ok)
    end
    if (wr_done === 1'b1)
    begin
      wv = wq.pop_front();
      `CHK("input enable", wv, wr_ok)
    end
    if (tmo === 1'b1)
    begin
      fail_count++;
      tally_and_finish();
    end
  end
  // write burst of n random bytes, en says if it is taken
  task automatic wburst(input logic [ADDR_W-1:0] s, int n, logic en);
    logic [DATA_W-1:0] d;
    h.latch(s);
    for (int i = 0; i < n; i++)
    begin
      d = DATA_W'($urandom);
      wq.push_back(en);
      h.wr(d);
      if (en)
        mem[ADDR_W'(s + i)] = d;
    end
    h.end_burst();
  endtask
  // read burst of n locations from s
  task automatic rburst(input logic [ADDR_W-1:0] s, int n);
    h.latch(s);
    `CHK("burst on", 1'b1, burst_active)
    for (int i = 0; i < n; i++)
    begin
      rq.push_back(mem[ADDR_W'(s + i)]);
      h.rd();
    end
    h.end_burst();
    `CHK("burst off", 1'b0, burst_active)
  endtask
  // main sequence
  initial
  begin
    fail_count = 0;
    n_checks = 0;
    reset_n = 1'b0;
    void'($urandom(26249));
    repeat (4) @(posedge clk);
    `CHK("reset ready", 1'b1, host_ready)
    `CHK("reset oe", 1'b0, data_oe)
    #1 reset_n = 1'b1;
    wburst(7'h7E, 4, 1'b1);
    h.mode(1'b1, 1'b0);
    wburst(7'h7F, 2, 1'b0);
    h.mode(1'b0, 1'b1);
    wburst(7'h00, 2, 1'b0);
    h.mode(1'b0, 1'b0);
    rburst(7'h7E, 4);
    rburst(7'h01, 1);
    a = ADDR_W'($urandom);
    wburst(a, 3, 1'b1);
    rburst(a, 3);
    repeat (4) @(posedge clk);
    tally_and_finish();
  end
endmodule // host_port_burst_bench
`default_nettype wire
